// ---- vsw_pkg.sv ----
// constants and types for the video switch control register bank
// assumes a single 10 MHz system clock and a two-wire host link on pins
package vsw_pkg;

    // device address: fixed upper six bits, then the select pin, then direction
    localparam logic [5:0] ADDR_FIXED = 6'h24;
    localparam logic DIR_WRITE = 1'b0;

    // number of control bytes in one write
    localparam int NUM_BYTES = 6;
    localparam logic [2:0] LAST_BYTE = 3'h5;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // byte indices
    localparam int IDX_ROUTE1 = 0;
    localparam int IDX_ROUTE2 = 1;
    localparam int IDX_GAIN = 2;
    localparam int IDX_IRQ = 3;
    localparam int IDX_GPIO = 4;
    localparam int IDX_FS = 5;

    // power-on contents, don't-care bits held at zero
    localparam logic [7:0] RST_VAL [NUM_BYTES] = '{8'h20, 8'hD4, 8'h00, 8'h40, 8'h0A, 8'h00};
    // writable bits of each byte
    localparam logic [7:0] WR_MASK [NUM_BYTES] = '{8'h7F, 8'hFC, 8'hEF, 8'hFF, 8'hCF, 8'hF0};

    // bit order of the five driver outputs
    localparam int DRV_PRI_COMP = 0;
    localparam int DRV_AUX_COMP = 1;
    localparam int DRV_AUX_CHROMA = 2;
    localparam int DRV_PRI_RED = 3;
    localparam int DRV_PRI_GB = 4;
    localparam int NUM_DRV = 5;

    // selector codes
    localparam logic [1:0] AD_SRC_PRIMARY = 2'h0;
    localparam logic [1:0] AD_SRC_AUX = 2'h1;
    localparam logic [1:0] PC_SRC_ENC_COMP = 2'h1;
    localparam logic [1:0] PC_SRC_ENC_LUMA = 2'h2;
    localparam logic [1:0] PC_SRC_MUTE = 2'h3;
    localparam logic [2:0] AC_SRC_ENC_COMP = 3'h2;
    localparam logic [2:0] AC_SRC_ENC_LUMA = 3'h3;
    localparam logic [1:0] CH_SRC_ENC = 2'h1;
    localparam logic [1:0] CH_SRC_MUTE_LOW = 2'h2;
    localparam logic [1:0] CH_SRC_MUTE_HIGH = 2'h3;
    localparam logic [1:0] RGB_SRC_ENC = 2'h0;
    localparam logic [1:0] BLANK_FORCE_0V = 2'h2;
    localparam logic [1:0] BLANK_FORCE_4V = 2'h3;
    localparam logic [1:0] FS_CODE_INPUT = 2'h0;
    localparam logic [1:0] FS_CODE_LOW = 2'h1;
    localparam logic [1:0] FS_CODE_MID = 2'h2;

    typedef enum logic [1:0] {
        VSW_FS_LOW = 2'b00,
        VSW_FS_MID = 2'b01,
        VSW_FS_HIGH = 2'b10
    } vsw_fs_level_e;

    typedef enum logic [2:0] {
        VSW_IDLE = 3'b000,
        VSW_ADDR = 3'b001,
        VSW_ACK_ADDR = 3'b010,
        VSW_DATA = 3'b011,
        VSW_ACK_DATA = 3'b100,
        VSW_IGNORE = 3'b101
    } vsw_state_e;

    // raw control fields as written by the host
    typedef struct packed {
        logic [1:0] input_ad_source_sel;
        logic [1:0] primary_composite_out_sel;
        logic [2:0] aux_composite_out_sel;
        logic [1:0] aux_chroma_out_sel;
        logic [1:0] primary_red_chroma_out_sel;
        logic [1:0] primary_green_blue_out_sel;
        logic red_chroma_preselect;
        logic [1:0] blanking_out_force;
        logic driver_gain_sel;
        logic rgb_filter_en;
        logic clamp_bias_sel;
        logic input_ad_gain_sel;
        logic irq_disable;
        logic aux_chroma_output_ctrl;
        logic primary_blue_output_ctrl;
        logic standby;
        logic luma_chroma_mix_sel;
        logic driver_filter_en;
        logic general_output_bit;
        logic rgb_gain_sel;
        logic [5:0] audio_switch_output;
        logic [1:0] primary_fs_level_field;
        logic [1:0] aux_fs_level_field;
    } vsw_cfg_s;

    // effective switch settings derived from the fields
    typedef struct packed {
        logic [4:0] drv_gain8;
        logic [4:0] drv_filter;
        logic [4:0] drv_mute;
        logic aux_chroma_mute_high;
        logic input_ad_mute;
        logic blank_force_en;
        logic blank_force_high;
        logic primary_fs_input_mode;
        logic aux_fs_input_mode;
        vsw_fs_level_e primary_fs_output_pin;
        vsw_fs_level_e aux_fs_output_pin;
    } vsw_drv_s;

endpackage

// ---- vsw_ctrl_regs.sv ----
// two-wire write slave and six-byte control bank of the video switch
// assumes scl/sda arrive asynchronously and toggle far slower than sys_clk_in
//
// Contract
// R1: START, address, six data bytes, each acknowledged
// R2: address 100100, select pin, direction bit
// R3: input-AD source: primary, aux, or mute
// R4: primary composite source select, mute on 11
// R5: aux composite source select, 1XX mutes
// R6: aux chroma source, two mute bias levels
// R7: primary red/chroma: encoder, aux, 1X mute
// R8: primary green/blue: encoder, aux, 1X mute
// R9: preselect picks encoder chroma or red
// R10: mix bit picks composite or luma/chroma mix
// R11: blanking: through, force 0V, force 4V
// R12: 8dB gain only on encoder-routed outputs
// R13: encoder-routed outputs always use filter
// R14: RGB filter bit routes RGB through filter
// R15: clamp/bias select for aux red/chroma input
// R16: input-AD gain and RGB gain bits
// R17: interrupt disable clears pending interrupt
// R18: chroma and blue output mode control bits
// R19: standby bit enters standby
// R20: general output and audio switch pins, defaults
// R21: function-switch pin levels and input mode
// R22: ignore don't-care bits and foreign addresses
`timescale 1ns/1ns
module vsw_ctrl_regs (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic srst_in,
    // two-wire link pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // address select pin
    input wire logic addr_sel_in,
    // control fields and effective settings
    output vsw_pkg::vsw_cfg_s cfg_out,
    output vsw_pkg::vsw_drv_s drv_out,
    // pulse that clears a pending interrupt
    output logic irq_clear_out
);

    // pin synchronisers
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic [1:0] adr_sync_reg;
    logic scl_prev_reg;
    logic sda_prev_reg;

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            adr_sync_reg <= 2'h0;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
            adr_sync_reg <= {adr_sync_reg[0], addr_sel_in};
            scl_prev_reg <= scl_sync_reg[1];
            sda_prev_reg <= sda_sync_reg[1];
        end
    end

    wire scl_s = scl_sync_reg[1];
    wire sda_s = sda_sync_reg[1];
    wire scl_rise = scl_s && !scl_prev_reg;
    wire scl_fall = !scl_s && scl_prev_reg;
    wire start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
    wire stop_det = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

    // link state
    vsw_pkg::vsw_state_e state_reg;
    vsw_pkg::vsw_state_e state_next;
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic [2:0] byte_idx_reg;
    logic byte_ok_reg;
    logic [7:0] data_reg [vsw_pkg::NUM_BYTES];

    wire [7:0] shift_in = {shift_reg[6:0], sda_s};
    wire byte_done = (bit_cnt_reg == vsw_pkg::BITS_PER_BYTE);
    wire addr_match = (shift_reg[7:2] == vsw_pkg::ADDR_FIXED) && (shift_reg[1] == adr_sync_reg[1])
        && (shift_reg[0] == vsw_pkg::DIR_WRITE); // R2 R22
    wire drive_ack = ((state_reg == vsw_pkg::VSW_ACK_ADDR) || (state_reg == vsw_pkg::VSW_ACK_DATA))
        && byte_ok_reg;
    wire data_store = (state_reg == vsw_pkg::VSW_DATA) && scl_fall && byte_done;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            vsw_pkg::VSW_IDLE: begin
                state_next = vsw_pkg::VSW_IDLE;
            end
            vsw_pkg::VSW_ADDR: begin
                if (scl_fall && byte_done) begin
                    state_next = addr_match ? vsw_pkg::VSW_ACK_ADDR : vsw_pkg::VSW_IGNORE; // R22
                end
            end
            vsw_pkg::VSW_ACK_ADDR, vsw_pkg::VSW_ACK_DATA: begin
                if (scl_fall) begin
                    state_next = byte_ok_reg ? vsw_pkg::VSW_DATA : vsw_pkg::VSW_IGNORE;
                end
            end
            vsw_pkg::VSW_DATA: begin
                if (scl_fall && byte_done) begin
                    state_next = vsw_pkg::VSW_ACK_DATA;
                end
            end
            vsw_pkg::VSW_IGNORE: begin
                state_next = vsw_pkg::VSW_IGNORE;
            end
            default: begin
                state_next = vsw_pkg::VSW_IDLE;
            end
        endcase
        if (start_det) begin
            state_next = vsw_pkg::VSW_ADDR;
        end else if (stop_det) begin
            state_next = vsw_pkg::VSW_IDLE;
        end
    end

    // receive path and acknowledge driver
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            state_reg <= vsw_pkg::VSW_IDLE;
            shift_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            byte_idx_reg <= 3'h0;
            byte_ok_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (start_det || (scl_fall && (state_reg == vsw_pkg::VSW_ACK_ADDR
                || state_reg == vsw_pkg::VSW_ACK_DATA))) begin
                bit_cnt_reg <= 4'h0;
            end else if (scl_rise && !byte_done) begin
                shift_reg <= shift_in;
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            if (start_det) begin
                byte_idx_reg <= 3'h0;
            end else if (state_reg == vsw_pkg::VSW_ADDR && scl_fall && byte_done) begin
                byte_ok_reg <= addr_match; // R1
            end else if (data_store) begin
                byte_ok_reg <= (byte_idx_reg <= vsw_pkg::LAST_BYTE); // R1
                byte_idx_reg <= byte_idx_reg + 3'h1;
            end
        end
    end

    // ack is a low drive held across the ninth clock
    assign sda_out = 1'b0;
    assign sda_oe_out = drive_ack; // R1

    // control bytes, each stored as its eighth bit completes
    genvar gi;
    generate
        for (gi = 0; gi < vsw_pkg::NUM_BYTES; gi++) begin : g_byte
            wire wr_this = data_store && (byte_idx_reg == 3'(gi));
            always_ff @(posedge sys_clk_in) begin
                if (srst_in) begin
                    data_reg[gi] <= vsw_pkg::RST_VAL[gi]; // R20
                end else if (wr_this) begin
                    data_reg[gi] <= shift_reg & vsw_pkg::WR_MASK[gi]; // R22
                end
            end
        end
    endgenerate

    // field extraction
    wire [7:0] b1 = data_reg[vsw_pkg::IDX_ROUTE1];
    wire [7:0] b2 = data_reg[vsw_pkg::IDX_ROUTE2];
    wire [7:0] b3 = data_reg[vsw_pkg::IDX_GAIN];
    wire [7:0] b4 = data_reg[vsw_pkg::IDX_IRQ];
    wire [7:0] b5 = data_reg[vsw_pkg::IDX_GPIO];
    wire [7:0] b6 = data_reg[vsw_pkg::IDX_FS];

    assign cfg_out.input_ad_source_sel = b1[6:5]; // R3
    assign cfg_out.primary_composite_out_sel = b1[4:3]; // R4
    assign cfg_out.aux_composite_out_sel = b1[2:0]; // R5
    assign cfg_out.aux_chroma_out_sel = b2[7:6]; // R6
    assign cfg_out.primary_red_chroma_out_sel = b2[5:4]; // R7
    assign cfg_out.primary_green_blue_out_sel = b2[3:2]; // R8
    assign cfg_out.red_chroma_preselect = b3[7]; // R9
    assign cfg_out.blanking_out_force = b3[6:5];
    assign cfg_out.driver_gain_sel = b3[3];
    assign cfg_out.rgb_filter_en = b3[2]; // R14
    assign cfg_out.clamp_bias_sel = b3[1]; // R15
    assign cfg_out.input_ad_gain_sel = b3[0]; // R16
    assign cfg_out.irq_disable = b4[7];
    assign cfg_out.aux_chroma_output_ctrl = b4[6]; // R18
    assign cfg_out.primary_blue_output_ctrl = b4[5]; // R18
    assign cfg_out.standby = b4[4]; // R19
    assign cfg_out.luma_chroma_mix_sel = b4[3]; // R10
    assign cfg_out.driver_filter_en = b4[2];
    assign cfg_out.general_output_bit = b5[7]; // R20
    assign cfg_out.rgb_gain_sel = b5[6]; // R16
    assign cfg_out.audio_switch_output = {b4[0], b4[1], b5[0], b5[1], b5[2], b5[3]}; // R20
    assign cfg_out.primary_fs_level_field = b6[7:6];
    assign cfg_out.aux_fs_level_field = b6[5:4];

    // which outputs carry an encoder input
    wire [vsw_pkg::NUM_DRV-1:0] enc_on;
    wire [vsw_pkg::NUM_DRV-1:0] mute_on;
    assign enc_on[vsw_pkg::DRV_PRI_COMP] = (b1[4:3] == vsw_pkg::PC_SRC_ENC_COMP)
        || (b1[4:3] == vsw_pkg::PC_SRC_ENC_LUMA);
    assign enc_on[vsw_pkg::DRV_AUX_COMP] = (b1[2:0] == vsw_pkg::AC_SRC_ENC_COMP)
        || (b1[2:0] == vsw_pkg::AC_SRC_ENC_LUMA);
    assign enc_on[vsw_pkg::DRV_AUX_CHROMA] = (b2[7:6] == vsw_pkg::CH_SRC_ENC);
    assign enc_on[vsw_pkg::DRV_PRI_RED] = (b2[5:4] == vsw_pkg::RGB_SRC_ENC);
    assign enc_on[vsw_pkg::DRV_PRI_GB] = (b2[3:2] == vsw_pkg::RGB_SRC_ENC);
    assign mute_on[vsw_pkg::DRV_PRI_COMP] = (b1[4:3] == vsw_pkg::PC_SRC_MUTE); // R4
    assign mute_on[vsw_pkg::DRV_AUX_COMP] = b1[2]; // R5
    assign mute_on[vsw_pkg::DRV_AUX_CHROMA] = b2[7]; // R6
    assign mute_on[vsw_pkg::DRV_PRI_RED] = b2[5]; // R7
    assign mute_on[vsw_pkg::DRV_PRI_GB] = b2[3]; // R8

    wire [1:0] fs_p = b6[7:6];
    wire [1:0] fs_a = b6[5:4];
    vsw_pkg::vsw_fs_level_e fs_p_lvl;
    vsw_pkg::vsw_fs_level_e fs_a_lvl;
    assign fs_p_lvl = (fs_p == vsw_pkg::FS_CODE_MID) ? vsw_pkg::VSW_FS_MID
        : (fs_p[1] ? vsw_pkg::VSW_FS_HIGH : vsw_pkg::VSW_FS_LOW); // R21
    assign fs_a_lvl = (fs_a == vsw_pkg::FS_CODE_MID) ? vsw_pkg::VSW_FS_MID
        : (fs_a[1] ? vsw_pkg::VSW_FS_HIGH : vsw_pkg::VSW_FS_LOW); // R21

    vsw_pkg::vsw_drv_s drv_next;
    assign drv_next.drv_gain8 = enc_on & {vsw_pkg::NUM_DRV{b3[3]}}; // R12
    assign drv_next.drv_filter = enc_on | {vsw_pkg::NUM_DRV{b4[2]}}; // R13
    assign drv_next.drv_mute = mute_on;
    assign drv_next.aux_chroma_mute_high = (b2[7:6] == vsw_pkg::CH_SRC_MUTE_HIGH); // R6
    assign drv_next.input_ad_mute = b1[6]; // R3
    assign drv_next.blank_force_en = b3[6]; // R11
    assign drv_next.blank_force_high = (b3[6:5] == vsw_pkg::BLANK_FORCE_4V); // R11
    assign drv_next.primary_fs_input_mode = (fs_p == vsw_pkg::FS_CODE_INPUT); // R21
    assign drv_next.aux_fs_input_mode = (fs_a == vsw_pkg::FS_CODE_INPUT); // R21
    assign drv_next.primary_fs_output_pin = fs_p_lvl;
    assign drv_next.aux_fs_output_pin = fs_a_lvl;

    logic irq_dis_prev_reg;
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            drv_out <= '0;
            irq_dis_prev_reg <= 1'b0;
            irq_clear_out <= 1'b0;
        end else begin
            drv_out <= drv_next;
            irq_dis_prev_reg <= b4[7];
            irq_clear_out <= b4[7] && !irq_dis_prev_reg; // R17
        end
    end

    // checks
    a_ack_needs_match: assert property (@(posedge sys_clk_in) disable iff (srst_in) // R2
        (state_reg == vsw_pkg::VSW_ADDR && scl_fall && byte_done && !addr_match)
        |=> !sda_oe_out [*2]) else $error("ack driven for foreign address");
    a_ack_held_slot: assert property (@(posedge sys_clk_in) disable iff (srst_in) // R1
        $rose(sda_oe_out) |-> (state_reg == vsw_pkg::VSW_ACK_ADDR || state_reg == vsw_pkg::VSW_ACK_DATA)
        && !scl_s) else $error("ack raised outside an ack slot");
    a_dontcare_zero: assert property (@(posedge sys_clk_in) disable iff (srst_in) // R22
        (b1 & ~vsw_pkg::WR_MASK[0]) == 8'h00 && (b5 & ~vsw_pkg::WR_MASK[4]) == 8'h00)
        else $error("don't-care bit stored");
    a_ignore_frozen: assert property (@(posedge sys_clk_in) disable iff (srst_in) // R22
        (state_reg == vsw_pkg::VSW_IGNORE) |=> $stable(b2) && $stable(b6))
        else $error("register changed in ignored transfer");
    a_gain_encoder: assert property (@(posedge sys_clk_in) disable iff (srst_in) // R12
        drv_out.drv_gain8[vsw_pkg::DRV_PRI_COMP] |-> $past(b3[3])
        && ($past(b1[4:3]) == vsw_pkg::PC_SRC_ENC_COMP || $past(b1[4:3]) == vsw_pkg::PC_SRC_ENC_LUMA))
        else $error("8dB on non-encoder output");
    a_filter_forced: assert property (@(posedge sys_clk_in) disable iff (srst_in) // R13
        enc_on[vsw_pkg::DRV_PRI_COMP] ##1 enc_on[vsw_pkg::DRV_PRI_COMP]
        |-> drv_out.drv_filter[vsw_pkg::DRV_PRI_COMP]) else $error("encoder output unfiltered");
    a_aux_mute_code: assert property (@(posedge sys_clk_in) disable iff (srst_in) // R5
        b1[2] |=> drv_out.drv_mute[vsw_pkg::DRV_AUX_COMP]) else $error("aux composite not muted");
    a_irq_clear_pulse: assert property (@(posedge sys_clk_in) disable iff (srst_in) // R17
        $rose(b4[7]) |=> irq_clear_out ##1 !irq_clear_out) else $error("interrupt clear pulse wrong");
    a_blank_force_4v: assert property (@(posedge sys_clk_in) disable iff (srst_in) // R11
        (b3[6:5] == vsw_pkg::BLANK_FORCE_4V) |=> drv_out.blank_force_en && drv_out.blank_force_high)
        else $error("blanking not forced high");
    a_fs_input_mode: assert property (@(posedge sys_clk_in) disable iff (srst_in) // R21
        (fs_p == vsw_pkg::FS_CODE_INPUT) |=> drv_out.primary_fs_input_mode
        && drv_out.primary_fs_output_pin == vsw_pkg::VSW_FS_LOW) else $error("fs input mode wrong");
    a_reset_values: assert property (@(posedge sys_clk_in) // R20
        $past(srst_in) |-> b4 == vsw_pkg::RST_VAL[3] && b5 == vsw_pkg::RST_VAL[4])
        else $error("reset contents wrong");

endmodule

// ---- vsw_host_model.sv ----
// two-wire host master model: start, address, data bytes, stop
// assumes the bench resolves the pulled-up data wire from all pull-downs
`timescale 1ns/1ns
module vsw_host_model (
    // clock
    input wire logic sys_clk_in,
    // link pins
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    // quarter of the 800 ns link period
    task automatic qtr();
        repeat (2) @(posedge sys_clk_in);
    endtask

    task automatic line_bit(input logic b, output logic s);
        sda_low_out <= !b;
        qtr();
        scl_out <= 1'b1;
        qtr();
        @(negedge sys_clk_in);
        s = sda_in;
        qtr();
        scl_out <= 1'b0;
        qtr();
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            line_bit(b[i], s);
        // released for the device's answer
        line_bit(1'b1, s);
        ack = !s;
    endtask

    // byte k of the frame sits at d[63-8k -: 8]; data goes on even after an address refusal
    task automatic write_frame(input logic [7:0] addr, input logic [63:0] d, input int n,
        output logic [8:0] acks);
        logic a;
        acks = '0;
        sda_low_out <= 1'b0;
        qtr();
        scl_out <= 1'b1;
        qtr();
        sda_low_out <= 1'b1;
        qtr();
        scl_out <= 1'b0;
        qtr();
        send_byte(addr, a);
        acks[0] = a;
        for (int k = 0; k < n; k++) begin
            send_byte(d[63-8*k -: 8], a);
            acks[k+1] = a;
        end
        sda_low_out <= 1'b1;
        qtr();
        scl_out <= 1'b1;
        qtr();
        sda_low_out <= 1'b0;
        qtr();
    endtask
endmodule

// ---- test_video_switch_i2c_control_regs.sv ----
// self-checking bench of the video switch control register bank
// assumes vsw_pkg, vsw_ctrl_regs and vsw_host_model are compiled first
`timescale 1ns/1ns
module test_video_switch_i2c_control_regs;
    logic sys_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic addr_sel_in = 1'b0;
    logic scl;
    logic host_low;
    logic sda_out;
    logic sda_oe_out;
    logic irq_clear_out;
    vsw_pkg::vsw_cfg_s cfg_out;
    vsw_pkg::vsw_drv_s drv_out;
    wire logic sda_wire = !host_low && !(sda_oe_out && !sda_out);
    int n_errors = 0;
    int comparisons = 0;
    int n_clr = 0;
    logic [47:0] cur;
    logic [8:0] acks;

    always #50 sys_clk_in = !sys_clk_in;
    always @(posedge sys_clk_in) if (irq_clear_out === 1'b1) n_clr++;

    vsw_ctrl_regs u_vsw_ctrl_regs (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .addr_sel_in(addr_sel_in),
        .cfg_out(cfg_out), .drv_out(drv_out), .irq_clear_out(irq_clear_out));
    vsw_host_model u_vsw_host_model (.sys_clk_in(sys_clk_in), .sda_in(sda_wire), .scl_out(scl),
        .sda_low_out(host_low));

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // six bytes, first byte in the top bits
    function automatic vsw_pkg::vsw_cfg_s cfg_of(input logic [47:0] d);
        vsw_pkg::vsw_cfg_s c;
        c.input_ad_source_sel = d[46:45];
        c.primary_composite_out_sel = d[44:43];
        c.aux_composite_out_sel = d[42:40];
        c.aux_chroma_out_sel = d[39:38];
        c.primary_red_chroma_out_sel = d[37:36];
        c.primary_green_blue_out_sel = d[35:34];
        c.red_chroma_preselect = d[31];
        c.blanking_out_force = d[30:29];
        c.driver_gain_sel = d[27];
        c.rgb_filter_en = d[26];
        c.clamp_bias_sel = d[25];
        c.input_ad_gain_sel = d[24];
        c.irq_disable = d[23];
        c.aux_chroma_output_ctrl = d[22];
        c.primary_blue_output_ctrl = d[21];
        c.standby = d[20];
        c.luma_chroma_mix_sel = d[19];
        c.driver_filter_en = d[18];
        c.general_output_bit = d[15];
        c.rgb_gain_sel = d[14];
        c.audio_switch_output = {d[16], d[17], d[8], d[9], d[10], d[11]};
        c.primary_fs_level_field = d[7:6];
        c.aux_fs_level_field = d[5:4];
        return c;
    endfunction

    task automatic wr(input logic [7:0] addr, input logic [63:0] d, input int n, input logic [8:0] exp_acks);
        u_vsw_host_model.write_frame(addr, d, n, acks);
        check("acks", acks, exp_acks);
        repeat (6) @(posedge sys_clk_in);
    endtask

    task automatic wr6(input logic [47:0] d);
        wr(8'h90, {d, 16'h0}, 6, 9'h07F);
        cur = d;
        check("cfg", cfg_out, cfg_of(cur));
    endtask

    task automatic s_reset();
        srst_in <= 1'b1;
        repeat (10) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        repeat (5) @(posedge sys_clk_in);
        check("cfg_rst", cfg_out, cfg_of(48'h20D400400A00));
        check("drv_rst", {drv_out.drv_gain8, drv_out.drv_filter, drv_out.drv_mute, drv_out.aux_chroma_mute_high,
            drv_out.primary_fs_input_mode, drv_out.aux_fs_input_mode, drv_out.blank_force_en},
            {15'h0004, 4'hE});
    endtask

    // host clears a pending interrupt first
    task automatic s_irq();
        n_clr = 0;
        wr6(48'h20D400C00A00);
        check("irq_clr", n_clr, 1);
        wr6(48'h20D400C00A00);
        wr6(48'h20D400400A00);
        check("irq_hold", n_clr, 1);
        wr6(48'h20D400C00A00);
        check("irq_again", n_clr, 2);
    endtask

    task automatic s_routes();
        logic [47:0] rows [6] = '{48'h0B439800300F, 48'h324300000000, 48'h011408040000,
            48'h001408000000, 48'h5CA800000000, 48'h7FFC00000000};
        logic [14:0] e [4] = '{15'h7FE0, 15'h03E0, 15'h03E0, 15'h0000};
        logic [6:0] m [2] = '{7'h7E, 7'h7F};
        for (int k = 0; k < 6; k++) begin
            wr6(rows[k]);
            if (k < 4)
                check("route", {drv_out.drv_gain8, drv_out.drv_filter, drv_out.drv_mute}, e[k]);
            else
                check("mute", {drv_out.drv_mute, drv_out.input_ad_mute, drv_out.aux_chroma_mute_high}, m[k-4]);
        end
    endtask

    task automatic s_blank_fs();
        vsw_pkg::vsw_fs_level_e lv [4] = '{vsw_pkg::VSW_FS_LOW, vsw_pkg::VSW_FS_LOW, vsw_pkg::VSW_FS_MID,
            vsw_pkg::VSW_FS_HIGH};
        logic [1:0] j;
        for (int k = 0; k < 4; k++) begin
            j = 2'(3 - k);
            wr6({16'h2000, 1'b0, 2'(k), 5'h1F, 16'h0000, 2'(k), j, 4'hF});
            check("blank", {drv_out.blank_force_en, drv_out.blank_force_high}, {k >= 2, k == 3});
            check("fs", {drv_out.primary_fs_input_mode, drv_out.aux_fs_input_mode, drv_out.primary_fs_output_pin,
                drv_out.aux_fs_output_pin}, {k == 0, j == 2'h0, lv[k], lv[j]});
        end
    endtask

    // seventh byte refused, then a short write keeps the rest
    task automatic s_extra();
        wr(8'h90, 64'h0AB0210CC55000FF, 7, 9'h07F);
        cur = 48'h0AB0210CC550;
        check("cfg7", cfg_out, cfg_of(cur));
        wr(8'h90, 64'h5511000000000000, 2, 9'h007);
        cur[47:32] = 16'h5511;
        check("cfg_short", cfg_out, cfg_of(cur));
    endtask

    task automatic s_addr();
        addr_sel_in <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        wr(8'h90, 64'h7FFCFFFFFFFF0000, 6, 9'h000);
        wr(8'h93, 64'h7FFCFFFFFFFF0000, 6, 9'h000);
        check("cfg_kept", cfg_out, cfg_of(cur));
        wr(8'h92, 64'h0DB3AE3ECF300000, 6, 9'h07F);
        cur = 48'h0DB3AE3ECF30;
        check("cfg_92", cfg_out, cfg_of(cur));
        addr_sel_in <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk_in);
        n_errors++;
        final_report();
    end

    initial begin
        s_reset();
        s_irq();
        s_routes();
        s_blank_fs();
        s_extra();
        s_addr();
        s_reset();
        final_report();
    end
endmodule
